// file: rtl/adc_cal_defines.vh
// register map, field positions, reset values and route codes for input select and calibration
//
// Behaviour
// R1: positive select is bits 7:4; codes 0-9 pick input pins, 1010 the common pin.
// R2: positive codes 1011-1110 pick temperature, analog, digital, test monitors; 1111 floats.
// R3: negative select is bits 3:0, same codes, negative monitor sides, 1111 floats.
// R4: input select at 06h resets to 01h: positive input 0, negative input 1.
// R5: 24-bit offset word from 07h (7:0), 08h (15:8), 09h (23:16).
// R6: offset word is two's complement, shifted left to align with 32-bit result.
// R7: aligned offset is subtracted from the result before gain correction.
// R8: offset bytes reset to zero, so no correction by default.
// R9: 24-bit unsigned gain word from 0Ah (7:0), 0Bh (15:8), 0Ch (23:16).
// R10: gain coefficient is gain word divided by 400000h; 400000h is unity.
// R11: offset-corrected result is multiplied by the gain coefficient, after subtraction.
// R12: gain bytes reset to 00h, 00h, 40h giving word 400000h, unity gain.
// R13: routing register 0Dh: source two bits 7:4, source one bits 3:0, reset BBh.
// R14: routing codes 0-9 pins, 1010 common, 1011 not connected, 1100-1111 reserved.
// R15: calibrated result saturates to 32-bit extremes on overflow.
`ifndef ADC_CAL_DEFINES_VH
`define ADC_CAL_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define ADDR_INPUT_SELECT    8'h06
`define ADDR_OFFSET_LOW      8'h07
`define ADDR_OFFSET_MID      8'h08
`define ADDR_OFFSET_HIGH     8'h09
`define ADDR_GAIN_LOW        8'h0a
`define ADDR_GAIN_MID        8'h0b
`define ADDR_GAIN_HIGH       8'h0c
`define ADDR_ROUTING         8'h0d

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_INPUT_SELECT     8'h01
`define RST_OFFSET_BYTE      8'h00
`define RST_GAIN_LOW         8'h00
`define RST_GAIN_MID         8'h00
`define RST_GAIN_HIGH        8'h40
`define RST_ROUTING          8'hbb

////////////////////////////////////////////////////////////////////////////////
// field positions
`define POS_SEL_HI           7
`define POS_SEL_LO           4
`define NEG_SEL_HI           3
`define NEG_SEL_LO           0
`define SRC_TWO_HI           7
`define SRC_TWO_LO           4
`define SRC_ONE_HI           3
`define SRC_ONE_LO           0

////////////////////////////////////////////////////////////////////////////////
// route codes
`define CODE_LAST_PIN        4'h9
`define CODE_COMMON          4'ha
`define CODE_TEMP_MON        4'hb
`define CODE_ANALOG_MON      4'hc
`define CODE_DIGITAL_MON     4'hd
`define CODE_TEST_SIG        4'he
`define CODE_FLOAT           4'hf
`define CODE_NO_CONNECT      4'hb

////////////////////////////////////////////////////////////////////////////////
// arithmetic
`define OFFSET_SHIFT         8
`define GAIN_UNITY_SHIFT     22

`endif

// file: rtl/adc_input_select_calibration.v
// register bank for input select, calibration words and current routing
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "adc_cal_defines.vh"

module adc_input_select_calibration (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // register port
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdata,
  // conversion result
  input  wire [31:0] rawData,
  input  wire        rawValid,
  output wire [31:0] calData,
  output wire        calValid,
  // analog routing
  output wire [3:0]  positiveInputSelect,
  output wire [3:0]  negativeInputSelect,
  output wire [10:0] positivePinSelect,
  output wire [3:0]  positiveMonitorSelect,
  output wire        positiveFloat,
  output wire [10:0] negativePinSelect,
  output wire [3:0]  negativeMonitorSelect,
  output wire        negativeFloat,
  output wire [10:0] sourceOnePinSelect,
  output wire [10:0] sourceTwoPinSelect,
  output wire        sourceOneReserved,
  output wire        sourceTwoReserved
);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] inputSelect_reg;
  reg [7:0] offsetLow_reg;
  reg [7:0] offsetMid_reg;
  reg [7:0] offsetHigh_reg;
  reg [7:0] gainLow_reg;
  reg [7:0] gainMid_reg;
  reg [7:0] gainHigh_reg;
  reg [7:0] routing_reg;
  reg [7:0] rdata_next;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inputSelect_reg <= `RST_INPUT_SELECT;  // [R4]
      offsetLow_reg   <= `RST_OFFSET_BYTE;   // [R8]
      offsetMid_reg   <= `RST_OFFSET_BYTE;   // [R8]
      offsetHigh_reg  <= `RST_OFFSET_BYTE;   // [R8]
      gainLow_reg     <= `RST_GAIN_LOW;      // [R12]
      gainMid_reg     <= `RST_GAIN_MID;      // [R12]
      gainHigh_reg    <= `RST_GAIN_HIGH;     // [R12]
      routing_reg     <= `RST_ROUTING;       // [R13]
    end else if (regWrite) begin
      case (regAddr)
        `ADDR_INPUT_SELECT: inputSelect_reg <= regWdata;  // [R4]
        `ADDR_OFFSET_LOW:   offsetLow_reg   <= regWdata;  // [R5]
        `ADDR_OFFSET_MID:   offsetMid_reg   <= regWdata;  // [R5]
        `ADDR_OFFSET_HIGH:  offsetHigh_reg  <= regWdata;  // [R5]
        `ADDR_GAIN_LOW:     gainLow_reg     <= regWdata;  // [R9]
        `ADDR_GAIN_MID:     gainMid_reg     <= regWdata;  // [R9]
        `ADDR_GAIN_HIGH:    gainHigh_reg    <= regWdata;  // [R9]
        `ADDR_ROUTING:      routing_reg     <= regWdata;  // [R13]
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read back, one cycle after the strobe, zero otherwise
  always @* begin
    rdata_next = 8'h00;
    case (regAddr)
      `ADDR_INPUT_SELECT: rdata_next = inputSelect_reg;
      `ADDR_OFFSET_LOW:   rdata_next = offsetLow_reg;
      `ADDR_OFFSET_MID:   rdata_next = offsetMid_reg;
      `ADDR_OFFSET_HIGH:  rdata_next = offsetHigh_reg;
      `ADDR_GAIN_LOW:     rdata_next = gainLow_reg;
      `ADDR_GAIN_MID:     rdata_next = gainMid_reg;
      `ADDR_GAIN_HIGH:    rdata_next = gainHigh_reg;
      `ADDR_ROUTING:      rdata_next = routing_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= rdata_next;
    else
      regRdata <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // field extraction
  assign positiveInputSelect = inputSelect_reg[`POS_SEL_HI:`POS_SEL_LO];  // [R1]
  assign negativeInputSelect = inputSelect_reg[`NEG_SEL_HI:`NEG_SEL_LO];  // [R3]

  wire [23:0] offsetWord = {offsetHigh_reg, offsetMid_reg, offsetLow_reg};  // [R5]
  wire [23:0] gainWord   = {gainHigh_reg, gainMid_reg, gainLow_reg};        // [R9]

  //////////////////////////////////////////////////////////////////////////////
  // decoders
  input_route_decoder u_pos (
    .code          (positiveInputSelect),
    .isMonitorSel  (1'b1),
    .pinSelect     (positivePinSelect),
    .monitorSelect (positiveMonitorSelect),
    .isFloating    (positiveFloat),
    .isReserved    ()
  );

  input_route_decoder u_neg (
    .code          (negativeInputSelect),
    .isMonitorSel  (1'b1),
    .pinSelect     (negativePinSelect),
    .monitorSelect (negativeMonitorSelect),
    .isFloating    (negativeFloat),
    .isReserved    ()
  );

  input_route_decoder u_src1 (
    .code          (routing_reg[`SRC_ONE_HI:`SRC_ONE_LO]),
    .isMonitorSel  (1'b0),
    .pinSelect     (sourceOnePinSelect),
    .monitorSelect (),
    .isFloating    (),
    .isReserved    (sourceOneReserved)
  );

  input_route_decoder u_src2 (
    .code          (routing_reg[`SRC_TWO_HI:`SRC_TWO_LO]),
    .isMonitorSel  (1'b0),
    .pinSelect     (sourceTwoPinSelect),
    .monitorSelect (),
    .isFloating    (),
    .isReserved    (sourceTwoReserved)
  );

  //////////////////////////////////////////////////////////////////////////////
  // calibration arithmetic
  cal_datapath u_cal (
    .clk        (clk),
    .reset_n    (reset_n),
    .offsetWord (offsetWord),
    .gainWord   (gainWord),
    .rawData    (rawData),
    .rawValid   (rawValid),
    .calData    (calData),
    .calValid   (calValid)
  );

endmodule // adc_input_select_calibration

// file: rtl/cal_datapath.v
// offset subtraction, gain multiply and saturation of a conversion result
`timescale 1ns/1ps
`include "adc_cal_defines.vh"

module cal_datapath (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // calibration words
  input  wire [23:0] offsetWord,
  input  wire [23:0] gainWord,
  // raw result
  input  wire [31:0] rawData,
  input  wire        rawValid,
  // calibrated result
  output reg  [31:0] calData,
  output reg         calValid
);

  wire signed [33:0] rawExt    = {{2{rawData[31]}}, rawData};
  wire signed [33:0] offExt    = {{2{offsetWord[23]}}, offsetWord, 8'h00};  // [R6]
  wire signed [33:0] corrected = rawExt - offExt;                           // [R7]
  wire signed [58:0] product   = corrected * $signed({1'b0, gainWord});     // [R11]
  wire signed [36:0] scaled    = product[58:22];                            // [R10]
  wire               overPos   = ~scaled[36] & (|scaled[35:31]);
  wire               overNeg   = scaled[36] & ~(&scaled[35:31]);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      calData  <= 32'h00000000;
      calValid <= 1'b0;
    end else begin
      calValid <= rawValid;
      if (rawValid) begin
        if (overPos)
          calData <= 32'h7fffffff;  // [R15]
        else if (overNeg)
          calData <= 32'h80000000;  // [R15]
        else
          calData <= scaled[31:0];
      end
    end
  end

endmodule // cal_datapath

// file: rtl/input_route_decoder.v
// one-hot decoder of a four-bit analog route code
`timescale 1ns/1ps
`include "adc_cal_defines.vh"

module input_route_decoder (
  // code in
  input  wire [3:0]  code,
  input  wire        isMonitorSel,
  // decoded
  output wire [10:0] pinSelect,
  output wire [3:0]  monitorSelect,
  output wire        isFloating,
  output wire        isReserved
);

  genvar i;
  generate
    for (i = 0; i < 11; i = i + 1) begin : g_pin
      localparam [3:0] PIN_CODE = i;
      assign pinSelect[i] = (code == PIN_CODE);  // [R1] [R14]
    end
  endgenerate

  assign monitorSelect[0] = isMonitorSel & (code == `CODE_TEMP_MON);     // [R2] [R3]
  assign monitorSelect[1] = isMonitorSel & (code == `CODE_ANALOG_MON);   // [R2] [R3]
  assign monitorSelect[2] = isMonitorSel & (code == `CODE_DIGITAL_MON);  // [R2] [R3]
  assign monitorSelect[3] = isMonitorSel & (code == `CODE_TEST_SIG);     // [R2] [R3]
  assign isFloating       = isMonitorSel & (code == `CODE_FLOAT);        // [R2] [R3]
  assign isReserved       = ~isMonitorSel & (code > `CODE_NO_CONNECT);   // [R14]

endmodule // input_route_decoder

// file: tb/adc_cal_monitor.sv
// checker for the calibration register bank
`timescale 1ns/1ps
module adc_cal_monitor (
  // clock and reset
  input wire        clk,
  input wire        reset_n,
  // register port
  input wire [7:0]  regAddr,
  input wire [7:0]  regWdata,
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regRdata,
  // datapath
  input wire        rawValid,
  input wire        calValid,
  // routing
  input wire [3:0]  positiveInputSelect,
  input wire [3:0]  negativeInputSelect,
  input wire [10:0] positivePinSelect,
  input wire        positiveFloat,
  input wire        sourceOneReserved
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_sel_fields: assert property (regWrite && regAddr == 8'h06 |=>
    {positiveInputSelect, negativeInputSelect} == $past(regWdata))
    else $error("input select fields wrong");
  a_sel_readback: assert property (regRead && regAddr == 8'h06 |=>
    regRdata == {$past(positiveInputSelect), $past(negativeInputSelect)})
    else $error("input select read wrong");
  a_offset_echo: assert property (regWrite && regAddr == 8'h09 ##1
    regRead && regAddr == 8'h09 |=> regRdata == $past(regWdata, 2))
    else $error("offset byte read wrong");
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside read cycle");
  a_cal_pulse: assert property (rawValid |=> calValid)
    else $error("calibrated result missing");
  a_cal_cause: assert property (calValid |-> $past(rawValid))
    else $error("calibrated result without raw");
  a_pin_onehot: assert property (positiveInputSelect <= 4'ha |->
    positivePinSelect == 11'h001 << positiveInputSelect)
    else $error("positive pin decode wrong");
  a_float_code: assert property (positiveFloat == (positiveInputSelect == 4'hf))
    else $error("float decode wrong");
  a_route_reserved: assert property (regWrite && regAddr == 8'h0d |=>
    sourceOneReserved == (($past(regWdata) & 8'h0c) == 8'h0c))
    else $error("reserved route flag wrong");
endmodule // adc_cal_monitor

bind adc_input_select_calibration adc_cal_monitor adc_cal_monitor_inst (.clk, .reset_n,
  .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .rawValid, .calValid,
  .positiveInputSelect, .negativeInputSelect, .positivePinSelect, .positiveFloat,
  .sourceOneReserved);

// file: tb/adc_input_select_calibration_bench.sv
// self-checking bench for the calibration register bank
`timescale 1ns/1ps
module adc_input_select_calibration_bench;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [7:0]  regWdata = 8'h00;
  reg         regWrite = 1'b0;
  reg         regRead = 1'b0;
  reg  [31:0] rawData = 32'h0;
  reg         rawValid = 1'b0;
  wire [7:0]  regRdata;
  wire [31:0] calData;
  wire        calValid;
  wire [10:0] posPin, negPin, srcOnePin, srcTwoPin;
  wire [3:0]  posMon, negMon;
  wire        posFloat, negFloat, srcOneRes, srcTwoRes;
  integer     seed = 5047;
  integer     bad_count = 0;
  integer     num_checks = 0;
  integer     i;
  reg  [7:0]  shadow [6:13];
  reg  [31:0] r;
  adc_input_select_calibration adc_input_select_calibration_inst (.clk, .reset_n,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .rawData, .rawValid,
    .calData, .calValid, .positiveInputSelect(), .negativeInputSelect(),
    .positivePinSelect(posPin), .positiveMonitorSelect(posMon), .positiveFloat(posFloat),
    .negativePinSelect(negPin), .negativeMonitorSelect(negMon), .negativeFloat(negFloat),
    .sourceOnePinSelect(srcOnePin), .sourceTwoPinSelect(srcTwoPin),
    .sourceOneReserved(srcOneRes), .sourceTwoReserved(srcTwoRes));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  function [7:0] rstVal(input [7:0] a);
    rstVal = a == 8'h06 ? 8'h01 : a == 8'h0c ? 8'h40 : a == 8'h0d ? 8'hbb : 8'h00;
  endfunction
  function [10:0] pinExp(input [3:0] c);
    pinExp = c <= 4'ha ? 11'h001 << c : 11'h000;
  endfunction
  function [31:0] calExp(input [31:0] raw, input [23:0] ofs, input [23:0] gn);
    reg signed [63:0] d;
    begin
      d = $signed(raw) - ($signed({{8{ofs[23]}}, ofs}) <<< 8);
      d = (d * $signed({40'h0, gn})) >>> 22;
      calExp = d > 64'sh7fffffff ? 32'h7fffffff : d < -64'sh80000000 ? 32'h80000000 : d[31:0];
    end
  endfunction
  ////////////////////////////////////////
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk("rdata", {24'h0, regRdata}, {24'h0, e});
    end
  endtask
  task run(input [31:0] raw, input [23:0] ofs, input [23:0] gn);
    begin
      for (i = 0; i < 3; i = i + 1) begin
        wr(8'h07 + i[7:0], ofs[8*i +: 8]);
        wr(8'h0a + i[7:0], gn[8*i +: 8]);
      end
      @(posedge clk);
      rawData <= raw;
      rawValid <= 1'b1;
      @(posedge clk);
      rawValid <= 1'b0;
      #1;
      chk("valid", {31'h0, calValid}, 32'h1);
      chk("caldata", calData, calExp(raw, ofs, gn));
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 5; i < 15; i = i + 1)
      rd(i[7:0], rstVal(i[7:0]));
    chk("defpins", {posPin, negPin}, {11'h001, 11'h002});
    $display("test reset done");
    for (i = 6; i < 14; i = i + 1) begin
      r = $random(seed);
      shadow[i] = r[7:0];
      wr(i[7:0], shadow[i]);
    end
    wr(8'h0e, 8'h5a);
    for (i = 6; i < 14; i = i + 1)
      rd(i[7:0], shadow[i]);
    rd(8'h0e, 8'h00);
    // write then read the same byte with no gap
    @(posedge clk);
    regAddr <= 8'h09;
    regWdata <= 8'hc3;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk("b2b", {24'h0, regRdata}, 32'h000000c3);
    $display("test readback done");
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h06, {i[3:0], ~i[3:0]});
      chk("pospin", posPin, pinExp(i[3:0]));
      chk("posmon", posMon, (i > 10 && i < 15) ? 4'h1 << (i - 11) : 4'h0);
      chk("float", {posFloat, negFloat}, {i == 15, i == 0});
      chk("negpin", negPin, pinExp(~i[3:0]));
      chk("negmon", negMon, (i > 0 && i < 5) ? 4'h1 << (4 - i) : 4'h0);
      wr(8'h0d, {~i[3:0], i[3:0]});
      chk("srcone", {srcOneRes, srcOnePin}, {i > 11, pinExp(i[3:0])});
      chk("srctwo", {srcTwoRes, srcTwoPin}, {i < 4, pinExp(~i[3:0])});
    end
    $display("test routing done");
    run(32'h12345678, 24'h000000, 24'h400000);
    run(32'h00001000, 24'hfffff0, 24'h200000);
    run(32'h7fffff00, 24'hffff00, 24'hffffff);
    run(32'h80000100, 24'h7fffff, 24'h400000);
    repeat (20) begin
      r = $random(seed);
      run($random(seed), r[23:0], {1'b0, r[30:8]});
    end
    $display("test calibration done");
    give_verdict;
  end
endmodule // adc_input_select_calibration_bench
